// ### common/drive_pkg.sv
// Constants, register map and types of the drive status output block
package drive_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int READY_DELAY_NS = 10000;
  localparam int READY_CYCLES_I = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_CNT_W = 10;
  localparam logic [READY_CNT_W-1:0] READY_LAST = READY_CNT_W'(READY_CYCLES_I - 1);

  localparam int NUM_TERM = 7;
  localparam int RUN_TERM = 0;
  localparam int RELAY_TERM = 6;
  localparam int CODE_W = 8;
  localparam logic [CODE_W-1:0] CODE_RUN = 8'h00;
  localparam logic [CODE_W-1:0] CODE_READY = 8'h0b;
  localparam logic [CODE_W-1:0] CODE_CDET = 8'h0c;
  localparam logic [CODE_W-1:0] CODE_FAULT = 8'h63;
  localparam logic [CODE_W-1:0] CODE_NEG_OFS = 8'h64;
  localparam logic [CODE_W-1:0] CODE_SPARE_RST = 8'h0b;

  localparam int CUR_W = 16;
  localparam int PROD_W = 24;
  localparam int LEVEL_W = 8;
  localparam int RATED_W = 16;
  localparam int DECEL_W = 24;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h6e;
  localparam logic [RATED_W-1:0] RATED_RST = 16'h03e8;
  localparam logic [DECEL_W-1:0] DECEL_RST = 24'h0003e8;
  localparam logic [PROD_W-1:0] PCT_SCALE = 24'h000064;

  localparam int ADDR_W = 8;
  localparam int WORD_LSB = 2;
  localparam int TERM_IDX_W = 3;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DECEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RATED = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TERM_BASE = 8'h20;
  localparam int CTRL_FAULT_RESET_BIT = 0;

  localparam int STAT_FAULT = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_RUN = 2;
  localparam int STAT_CDET = 3;
  localparam int STAT_STATE_LSB = 4;
  localparam int STATE_W = 3;

  localparam int IRQ_W = 5;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_READY = 1;
  localparam int IRQ_RUN_START = 2;
  localparam int IRQ_RUN_STOP = 3;
  localparam int IRQ_CDET = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [STATE_W-1:0] {ST_POWERUP, ST_READY, ST_RUN, ST_DECEL, ST_TRIP}
    drive_state_t;

  typedef struct packed {
    logic fault_trip_output;
    logic ready_status_output;
    logic running;
    logic current_detected_output;
  } drive_status_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage

// ### hdl/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // sync2

// ### hdl/terminal_select.sv
// Function code decoder for one output terminal
`timescale 1ns/100ps
module terminal_select
  import drive_pkg::*;
(
  input  wire logic [CODE_W-1:0] code_in,
  input  wire drive_status_t     status_in,
  output logic                   level_out
);
  logic              neg;
  logic [CODE_W-1:0] base;
  logic              sel;
  logic              known;

  assign neg = (code_in >= CODE_NEG_OFS);
  assign base = neg ? code_in - CODE_NEG_OFS : code_in;

  always_comb begin
    sel = 1'b0;
    known = 1'b1;
    case (base)
      CODE_FAULT: sel = status_in.fault_trip_output;
      CODE_READY: sel = status_in.ready_status_output;
      CODE_RUN:   sel = status_in.running;
      CODE_CDET:  sel = status_in.current_detected_output;
      default:    known = 1'b0;
    endcase
  end

  // Adding the offset inverts the sense
  assign level_out = known & (sel ^ neg);
endmodule // terminal_select

// ### hdl/drive_status_outputs.sv
// Drive state, status outputs, terminal routing and register slave
// How it works
// - Fault trips drive, stops output, flags fault
// - Fault output selectable negative: high when healthy
// - Ready asserted once powered and able to run
// - Running held through deceleration until output stops
// - Current detect while running, above programmable level, default 110%
// - Reset routes fault to relay, running to run
// - Codes 99/11/0/12; plus 100 selects negative
`timescale 1ns/100ps
module drive_status_outputs
  import drive_pkg::*;
(
  input  wire logic            clock_in,
  input  wire logic            rst_in,
  input  wire axil_req_t       axi_req_in,
  output axil_rsp_t            axi_rsp_out,
  input  wire logic            fault_detect_in,
  input  wire logic            power_good_in,
  input  wire logic            forward_start_input_in,
  input  wire logic            reverse_start_input_in,
  input  wire logic [CUR_W-1:0] motor_current_in,
  output logic                 drive_enable_out,
  output logic                 relay_contact_terminal_out,
  output logic                 running_terminal_out,
  output logic [NUM_TERM-3:0]  out_terminal_out,
  output logic                 irq_out
);

  function automatic logic reg_hit(input logic [31:0] a, input logic [ADDR_W-1:0] ofs);
    reg_hit = (a[31:ADDR_W] == '0) && (a[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
  endfunction

  function automatic logic term_hit(input logic [31:0] a);
    term_hit = (a[31:ADDR_W] == '0)
      && (a[ADDR_W-1:WORD_LSB+TERM_IDX_W] == OFS_TERM_BASE[ADDR_W-1:WORD_LSB+TERM_IDX_W])
      && (a[WORD_LSB+:TERM_IDX_W] < TERM_IDX_W'(NUM_TERM));
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old[b*8+:8] = d[b*8+:8];
      end
    end
    wmerge = old;
  endfunction

  // Pin synchronisers
  logic [3:0] pins_s;
  logic       fault_s;
  logic       power_s;
  logic       fwd_s;
  logic       rev_s;
  logic       start_s;

  sync2 #(.W(4)) u_pin_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     ({fault_detect_in, power_good_in, forward_start_input_in,
                reverse_start_input_in}),
    .q_out    (pins_s)
  );

  assign {fault_s, power_s, fwd_s, rev_s} = pins_s;
  assign start_s = fwd_s | rev_s;

  drive_state_t            state_q;
  drive_state_t            state_d;
  logic [READY_CNT_W-1:0]  ready_cnt_q;
  logic [READY_CNT_W-1:0]  ready_cnt_d;
  logic [DECEL_W-1:0]      decel_cnt_q;
  logic [DECEL_W-1:0]      decel_cnt_d;
  logic [DECEL_W-1:0]      decel_q;
  logic [LEVEL_W-1:0]      level_q;
  logic [RATED_W-1:0]      rated_q;
  logic [CODE_W-1:0]       sel_q [NUM_TERM];
  logic [IRQ_W-1:0]        irq_stat_q;
  logic [IRQ_W-1:0]        irq_stat_d;
  logic [IRQ_W-1:0]        irq_mask_q;
  logic [IRQ_W-1:0]        irq_ev;
  drive_status_t           status_q;
  drive_status_t           status_d;
  logic [NUM_TERM-1:0]     term_q;
  logic [NUM_TERM-1:0]     term_w;
  logic                    drive_en_q;
  logic                    irq_q;
  logic                    fault_reset_w;
  logic                    running_w;
  logic                    over_w;
  logic [PROD_W-1:0]       cur_x100;
  logic [PROD_W-1:0]       thr;

  // Drive sequencing
  always_comb begin
    state_d = state_q;
    ready_cnt_d = ready_cnt_q;
    decel_cnt_d = decel_cnt_q;
    if (fault_s) begin
      state_d = ST_TRIP;
    end else if (!power_s && state_q != ST_TRIP) begin
      state_d = ST_POWERUP;
      ready_cnt_d = '0;
    end else begin
      case (state_q)
        ST_POWERUP: begin
          if (ready_cnt_q == READY_LAST) begin
            state_d = ST_READY;
          end else begin
            ready_cnt_d = ready_cnt_q + 1'b1;
          end
        end
        ST_READY: begin
          if (start_s) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!start_s) begin
            state_d = ST_DECEL;
            decel_cnt_d = decel_q;
          end
        end
        ST_DECEL: begin
          if (start_s) begin
            state_d = ST_RUN;
          end else if (decel_cnt_q == '0) begin
            state_d = ST_READY;
          end else begin
            decel_cnt_d = decel_cnt_q - 1'b1;
          end
        end
        ST_TRIP: begin
          if (fault_reset_w) begin
            state_d = ST_POWERUP;
            ready_cnt_d = '0;
          end
        end
        default: state_d = ST_POWERUP;
      endcase
    end
  end

  // Status derivation
  assign running_w = (state_q == ST_RUN) || (state_q == ST_DECEL);
  assign cur_x100 = PROD_W'(motor_current_in) * PCT_SCALE;
  assign thr = PROD_W'(rated_q) * PROD_W'(level_q);
  assign over_w = cur_x100 > thr;
  assign status_d.fault_trip_output = (state_q == ST_TRIP);
  assign status_d.ready_status_output = running_w || (state_q == ST_READY);
  assign status_d.running = running_w;
  assign status_d.current_detected_output = running_w && over_w;

  assign irq_ev[IRQ_TRIP] = status_d.fault_trip_output & ~status_q.fault_trip_output;
  assign irq_ev[IRQ_READY] = status_d.ready_status_output & ~status_q.ready_status_output;
  assign irq_ev[IRQ_RUN_START] = status_d.running & ~status_q.running;
  assign irq_ev[IRQ_RUN_STOP] = ~status_d.running & status_q.running;
  assign irq_ev[IRQ_CDET] =
    status_d.current_detected_output & ~status_q.current_detected_output;

  // Terminal function selection
  for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
    terminal_select u_sel (
      .code_in   (sel_q[i]),
      .status_in (status_q),
      .level_out (term_w[i])
    );
  end

  // Register slave
  axil_rsp_t                rsp_q;
  logic                     aw_full_q;
  logic                     w_full_q;
  logic [31:0]              awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     aw_take;
  logic                     w_take;
  logic                     ar_take;
  logic                     wr_fire;
  logic                     aw_full_d;
  logic                     w_full_d;
  logic                     bvalid_d;
  logic                     rvalid_d;
  logic [31:0]              wr_addr;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;
  logic                     wr_term;
  logic                     wr_ok;
  logic [TERM_IDX_W-1:0]    wr_idx;
  logic [TERM_IDX_W-1:0]    rd_idx;
  logic [31:0]              decel_m;
  logic [31:0]              level_m;
  logic [31:0]              rated_m;
  logic [31:0]              mask_m;
  logic [31:0]              term_m;
  logic [31:0]              status_word;
  logic [31:0]              rd_word;
  logic                     rd_ok;
  logic                     irq_clr;

  assign aw_take = axi_req_in.awvalid & rsp_q.awready;
  assign w_take = axi_req_in.wvalid & rsp_q.wready;
  assign ar_take = axi_req_in.arvalid & rsp_q.arready;
  assign wr_fire = (aw_full_q | aw_take) & (w_full_q | w_take);
  assign aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  assign w_full_d = (w_full_q | w_take) & ~wr_fire;
  assign bvalid_d = wr_fire | (rsp_q.bvalid & ~axi_req_in.bready);
  assign rvalid_d = ar_take | (rsp_q.rvalid & ~axi_req_in.rready);

  assign wr_addr = aw_take ? axi_req_in.awaddr : awaddr_q;
  assign wr_data = w_take ? axi_req_in.wdata : wdata_q;
  assign wr_strb = w_take ? axi_req_in.wstrb : wstrb_q;
  assign wr_idx = wr_addr[WORD_LSB+:TERM_IDX_W];
  assign wr_term = term_hit(wr_addr);
  assign wr_ok = wr_term || reg_hit(wr_addr, OFS_CTRL) || reg_hit(wr_addr, OFS_STATUS)
    || reg_hit(wr_addr, OFS_DECEL) || reg_hit(wr_addr, OFS_LEVEL)
    || reg_hit(wr_addr, OFS_RATED) || reg_hit(wr_addr, OFS_IRQ_STAT)
    || reg_hit(wr_addr, OFS_IRQ_MASK);
  assign decel_m = wmerge(32'(decel_q), wr_data, wr_strb);
  assign level_m = wmerge(32'(level_q), wr_data, wr_strb);
  assign rated_m = wmerge(32'(rated_q), wr_data, wr_strb);
  assign mask_m = wmerge(32'(irq_mask_q), wr_data, wr_strb);
  assign term_m = wmerge(32'(sel_q[wr_idx]), wr_data, wr_strb);
  assign fault_reset_w = wr_fire && reg_hit(wr_addr, OFS_CTRL) && wr_strb[0]
    && wr_data[CTRL_FAULT_RESET_BIT];

  always_comb begin
    status_word = '0;
    status_word[STAT_FAULT] = status_q.fault_trip_output;
    status_word[STAT_READY] = status_q.ready_status_output;
    status_word[STAT_RUN] = status_q.running;
    status_word[STAT_CDET] = status_q.current_detected_output;
    status_word[STAT_STATE_LSB+:STATE_W] = state_q;
  end

  assign rd_idx = axi_req_in.araddr[WORD_LSB+:TERM_IDX_W];
  assign rd_word =
    reg_hit(axi_req_in.araddr, OFS_STATUS)   ? status_word :
    reg_hit(axi_req_in.araddr, OFS_DECEL)    ? 32'(decel_q) :
    reg_hit(axi_req_in.araddr, OFS_LEVEL)    ? 32'(level_q) :
    reg_hit(axi_req_in.araddr, OFS_RATED)    ? 32'(rated_q) :
    reg_hit(axi_req_in.araddr, OFS_IRQ_STAT) ? 32'(irq_stat_q) :
    reg_hit(axi_req_in.araddr, OFS_IRQ_MASK) ? 32'(irq_mask_q) :
    term_hit(axi_req_in.araddr)              ? 32'(sel_q[rd_idx]) : 32'h0000_0000;
  assign rd_ok = term_hit(axi_req_in.araddr) || reg_hit(axi_req_in.araddr, OFS_CTRL)
    || reg_hit(axi_req_in.araddr, OFS_STATUS) || reg_hit(axi_req_in.araddr, OFS_DECEL)
    || reg_hit(axi_req_in.araddr, OFS_LEVEL) || reg_hit(axi_req_in.araddr, OFS_RATED)
    || reg_hit(axi_req_in.araddr, OFS_IRQ_STAT)
    || reg_hit(axi_req_in.araddr, OFS_IRQ_MASK);

  // Read clears, a new event wins
  assign irq_clr = ar_take && reg_hit(axi_req_in.araddr, OFS_IRQ_STAT);
  assign irq_stat_d = (irq_stat_q & ~{IRQ_W{irq_clr}}) | irq_ev;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rsp_q     <= '0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      rsp_q.awready <= ~aw_full_d & ~bvalid_d;
      rsp_q.wready  <= ~w_full_d & ~bvalid_d;
      rsp_q.bvalid  <= bvalid_d;
      rsp_q.arready <= ~rvalid_d;
      rsp_q.rvalid  <= rvalid_d;
      if (aw_take) begin
        awaddr_q <= axi_req_in.awaddr;
      end
      if (w_take) begin
        wdata_q <= axi_req_in.wdata;
        wstrb_q <= axi_req_in.wstrb;
      end
      if (wr_fire) begin
        rsp_q.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rsp_q.rdata <= rd_word;
        rsp_q.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Settings and selectors
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      decel_q    <= DECEL_RST;
      level_q    <= LEVEL_RST;
      rated_q    <= RATED_RST;
      irq_mask_q <= '0;
      for (int i = 0; i < NUM_TERM; i++) begin
        sel_q[i] <= CODE_SPARE_RST;
      end
      sel_q[RELAY_TERM] <= CODE_FAULT;
      sel_q[RUN_TERM]   <= CODE_RUN;
    end else if (wr_fire) begin
      if (reg_hit(wr_addr, OFS_DECEL)) begin
        decel_q <= decel_m[DECEL_W-1:0];
      end
      if (reg_hit(wr_addr, OFS_LEVEL)) begin
        level_q <= level_m[LEVEL_W-1:0];
      end
      if (reg_hit(wr_addr, OFS_RATED)) begin
        rated_q <= rated_m[RATED_W-1:0];
      end
      if (reg_hit(wr_addr, OFS_IRQ_MASK)) begin
        irq_mask_q <= mask_m[IRQ_W-1:0];
      end
      if (wr_term) begin
        sel_q[wr_idx] <= term_m[CODE_W-1:0];
      end
    end
  end

  // Drive state and outputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q     <= ST_POWERUP;
      ready_cnt_q <= '0;
      decel_cnt_q <= '0;
      status_q    <= '0;
      term_q      <= '0;
      drive_en_q  <= 1'b0;
      irq_stat_q  <= '0;
      irq_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      ready_cnt_q <= ready_cnt_d;
      decel_cnt_q <= decel_cnt_d;
      status_q    <= status_d;
      term_q      <= term_w;
      drive_en_q  <= running_w;
      irq_stat_q  <= irq_stat_d;
      irq_q       <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign axi_rsp_out = rsp_q;
  assign drive_enable_out = drive_en_q;
  assign relay_contact_terminal_out = term_q[RELAY_TERM];
  assign running_terminal_out = term_q[RUN_TERM];
  assign out_terminal_out = term_q[RELAY_TERM-1:RUN_TERM+1];
  assign irq_out = irq_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_trip;
    fault_s |=> (state_q == ST_TRIP) ##1 (status_q.fault_trip_output && !drive_enable_out);
  endproperty
  a_trip: assert property (p_trip) else $error("fault did not trip");

  property p_neg_fault;
    sel_q[RELAY_TERM] == CODE_FAULT + CODE_NEG_OFS
      |=> relay_contact_terminal_out == !$past(status_q.fault_trip_output);
  endproperty
  a_neg_fault: assert property (p_neg_fault) else $error("negative fault level wrong");

  property p_ready;
    (state_q == ST_POWERUP && power_s && !fault_s && ready_cnt_q == READY_LAST)
      |=> (state_q == ST_READY) ##1 status_q.ready_status_output;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not raised");

  property p_decel_enter;
    (state_q == ST_RUN && !start_s && !fault_s && power_s)
      |=> (state_q == ST_DECEL) ##1 status_q.running;
  endproperty
  a_decel_enter: assert property (p_decel_enter) else $error("running dropped early");

  property p_decel_hold;
    (state_q == ST_DECEL && decel_cnt_q != '0 && !start_s && !fault_s && power_s)
      |=> state_q == ST_DECEL && decel_cnt_q == $past(decel_cnt_q) - 1'b1;
  endproperty
  a_decel_hold: assert property (p_decel_hold) else $error("deceleration cut short");

  property p_cdet;
    !$past(rst_in) |-> status_q.current_detected_output == $past(running_w
      && 32'(motor_current_in) * 32'(PCT_SCALE) > 32'(rated_q) * 32'(level_q));
  endproperty
  a_cdet: assert property (p_cdet) else $error("current detect mismatch");

  property p_rst_map;
    $past(rst_in) |-> sel_q[RELAY_TERM] == CODE_FAULT && sel_q[RUN_TERM] == CODE_RUN;
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("reset routing wrong");

  // Code checks on every terminal
  for (genvar i = 0; i < NUM_TERM; i++) begin : g_code_chk
    property p_code_ready;
      @(posedge clock_in) disable iff (rst_in)
      sel_q[i] == CODE_READY |=> term_q[i] == $past(status_q.ready_status_output);
    endproperty
    a_code_ready: assert property (p_code_ready) else $error("ready code misrouted");

    property p_code_cdet_neg;
      @(posedge clock_in) disable iff (rst_in)
      sel_q[i] == CODE_CDET + CODE_NEG_OFS
        |=> term_q[i] == !$past(status_q.current_detected_output);
    endproperty
    a_code_cdet_neg: assert property (p_code_cdet_neg) else $error("code 112 wrong");
  end

  property p_irq;
    !$past(rst_in) |-> irq_out == |(irq_stat_q & $past(irq_mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule // drive_status_outputs

// ### test/interlock_monitor.sv
// Interlock monitor model watching the drive status terminals
`timescale 1ns/100ps
module interlock_monitor #(
  parameter int READY_WAIT = 1100,
  parameter int START_LAG  = 8,
  parameter int DECEL_WIN  = 60
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             power_in,
  input  wire logic             start_in,
  input  wire logic             ready_in,
  input  wire logic             run_in,
  input  wire logic             cdet_in,
  input  wire logic [2:0][15:0] phase_cur_in,
  input  wire logic [15:0]      cmd_speed_in,
  input  wire logic [15:0]      meas_speed_in,
  output logic                  alarm_out
);
  int   pw_q;
  int   on_q;
  int   tail_q;
  int   cur_q;
  int   spd_q;
  logic moving;
  // Any phase carrying current
  assign moving = |phase_cur_in[0] || |phase_cur_in[1] || |phase_cur_in[2];
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pw_q      <= 0;
      on_q      <= 0;
      tail_q    <= 0;
      cur_q     <= 0;
      spd_q     <= 0;
      alarm_out <= 1'b0;
    end else begin
      cur_q  <= (!start_in && moving) ? cur_q + 1 : 0;
      spd_q  <= (cmd_speed_in != meas_speed_in) ? spd_q + 1 : 0;
      if (cur_q > DECEL_WIN) alarm_out <= 1'b1;
      if (spd_q > DECEL_WIN) alarm_out <= 1'b1;
      pw_q   <= (power_in && !ready_in) ? pw_q + 1 : 0;
      on_q   <= start_in ? on_q + 1 : 0;
      tail_q <= (!start_in && (run_in || cdet_in)) ? tail_q + 1 : 0;
      if (pw_q > READY_WAIT) alarm_out <= 1'b1;
      if (on_q > START_LAG && !run_in) alarm_out <= 1'b1;
      if (tail_q > DECEL_WIN) alarm_out <= 1'b1;
    end
  end
endmodule // interlock_monitor

// ### test/drive_status_outputs_tb.sv
// Self-checking bench for the drive status output block
`timescale 1ns/100ps
module drive_status_outputs_tb;
  import drive_pkg::*;
  logic                clk = 0, rst = 1, fault = 0, power = 0, fwd = 0, rev = 0;
  logic [CUR_W-1:0]    cur = '0;
  axil_req_t           req = '0;
  axil_rsp_t           rsp;
  logic                den, relay, runt, irq, alarm;
  logic [NUM_TERM-3:0] terms;
  logic [1:0]          resp;
  logic [31:0]         rdat;
  int                  error_cnt = 0, checks_done = 0, cyc = 0;
  int                  codes[$] = '{0, 11, 12, 99, 100, 111, 112, 150, 199};
  logic [7:0]          ra[7] = '{8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h38, 8'h24};
  logic [31:0]         rv[7] = '{32'h3e8, 32'h6e, 32'h3e8, 32'h0, 32'h0, 32'h63, 32'h0b};

  always #5 clk = ~clk;

  drive_status_outputs u_drive_status_outputs (.clock_in(clk), .rst_in(rst),
    .axi_req_in(req), .axi_rsp_out(rsp), .fault_detect_in(fault), .power_good_in(power),
    .forward_start_input_in(fwd), .reverse_start_input_in(rev), .motor_current_in(cur),
    .drive_enable_out(den), .relay_contact_terminal_out(relay),
    .running_terminal_out(runt), .out_terminal_out(terms), .irq_out(irq));

  interlock_monitor u_interlock_monitor (.clock_in(clk), .rst_in(rst), .power_in(power),
    .start_in(fwd | rev), .ready_in(terms[2]), .run_in(runt), .cdet_in(terms[0]),
    .phase_cur_in({cur, cur, cur}), .cmd_speed_in((fwd | rev) ? 16'h0100 : 16'h0000),
    .meas_speed_in(den ? 16'h0100 : 16'h0000), .alarm_out(alarm));

  // Expected terminal level, st = {cdet, run, ready, fault}
  function automatic logic tlev(int code, logic [3:0] st);
    int   b = code % 100;
    logic v;
    case (b)
      99: v = st[0];
      11: v = st[1];
      0: v = st[2];
      12: v = st[3];
      default: return 1'b0;
    endcase
    return (code >= 100) ? ~v : v;
  endfunction

  task automatic chk(logic [31:0] g, logic [31:0] e, string m);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {24'h0, a};
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    while (!rsp.bvalid) @(posedge clk);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rdr(logic [7:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {24'h0, a};
    req.rready  <= 1'b1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  initial begin
    void'($urandom(67196));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rdr(ra[i]);
      chk(rdat, rv[i], "reset value");
    end
    rdr(8'h1c);
    chk(rdat, 32'h0, "unmapped read data");
    chk(resp, RESP_SLVERR, "unmapped read");
    wr(8'h40, 32'h5);
    chk(resp, RESP_SLVERR, "unmapped write");
    wr(8'h24, 32'h0c);
    $display("test registers done");
    @(posedge clk);
    power <= 1'b1;
    repeat (990) @(posedge clk);
    rdr(OFS_STATUS);
    chk(rdat[1], 0, "early ready");
    repeat (30) @(posedge clk);
    rdr(OFS_STATUS);
    chk(rdat, 32'h12, "ready status");
    chk(terms[2], 1, "ready terminal");
    rdr(OFS_IRQ_STAT);
    chk(rdat, 32'h2, "ready event");
    rdr(OFS_IRQ_STAT);
    chk(rdat, 0, "event cleared");
    chk(irq, 0, "masked irq");
    wr(OFS_IRQ_MASK, 32'h1);
    $display("test ready done");
    foreach (codes[i]) begin
      wr(8'h28, 32'(codes[i]));
      repeat (4) @(posedge clk);
      chk(terms[1], tlev(codes[i], 4'b0010), "function code");
    end
    $display("test codes done");
    wr(OFS_DECEL, 32'd30);
    wr(OFS_LEVEL, 32'd20);
    for (int dir = 0; dir < 2; dir++) begin
      @(posedge clk);
      fwd <= (dir == 0);
      rev <= (dir == 1);
      for (int k = 0; k < 6; k++) begin
        int c;
        c = (k < 2) ? 200 + k : $urandom_range(400);
        @(posedge clk);
        cur <= CUR_W'(c);
        repeat (8) @(posedge clk);
        chk(runt, 1, "running");
        chk(terms[0], c > 200, "current detect");
      end
      @(posedge clk);
      cur <= '0;
      fwd <= 1'b0;
      rev <= 1'b0;
      repeat (20) @(posedge clk);
      chk(runt, 1, "decel tail");
      repeat (30) @(posedge clk);
      chk(runt, 0, "stopped");
    end
    chk(alarm, 0, "monitor alarm");
    chk(irq, 0, "masked run events");
    $display("test run done");
    @(posedge clk);
    fwd <= 1'b1;
    repeat (8) @(posedge clk);
    chk(den, 1, "drive running");
    fault <= 1'b1;
    repeat (8) @(posedge clk);
    chk(den, 0, "drive stopped");
    chk(alarm, 1, "monitor sees trip");
    chk(relay, 1, "relay fault");
    chk(terms[1], 0, "negative fault");
    chk(irq, 1, "trip irq");
    rdr(OFS_STATUS);
    chk(rdat & 32'h71, 32'h41, "trip status");
    rdr(OFS_IRQ_STAT);
    chk(rdat[0], 1, "trip event");
    repeat (3) @(posedge clk);
    chk(irq, 0, "irq cleared");
    wr(8'h38, 32'd199);
    repeat (3) @(posedge clk);
    chk(relay, 0, "negative relay");
    fault <= 1'b0;
    fwd <= 1'b0;
    repeat (4) @(posedge clk);
    wr(OFS_CTRL, 32'h1);
    rdr(OFS_STATUS);
    chk(rdat & 32'h71, 32'h0, "fault reset");
    $display("test trip done");
    tally_and_finish;
  end
endmodule // drive_status_outputs_tb
